/* File: rtl/tgw_pkg.sv */
// Purpose: Shared constants for the timer group with watchdogs
// Assumes: Avalon-MM word addressing, 32-bit data
// Notes: Address is {block[4:0], register[2:0]}
package tgw_pkg;
    localparam int NUM_TMR = 4;
    localparam int NUM_WD = 3;
    localparam int NUM_STG = 4;
    // Block numbers
    localparam logic [4:0] BLK_WD0 = 5'h04;
    localparam logic [4:0] BLK_INT = 5'h07;
    // Timer block registers
    localparam logic [2:0] TR_CFG = 3'h0;
    localparam logic [2:0] TR_CNT_LO = 3'h1;
    localparam logic [2:0] TR_CNT_HI = 3'h2;
    localparam logic [2:0] TR_ALM_LO = 3'h3;
    localparam logic [2:0] TR_ALM_HI = 3'h4;
    localparam logic [2:0] TR_LD_LO = 3'h5;
    localparam logic [2:0] TR_LD_HI = 3'h6;
    localparam logic [2:0] TR_RELOAD = 3'h7;
    // Timer config fields
    localparam int TC_EN = 0;
    localparam int TC_UP = 1;
    localparam int TC_AR = 2;
    localparam int TC_EDGE = 3;
    localparam int TC_ALEN = 4;
    localparam int TC_DIV_LSB = 16;
    localparam logic [31:0] TMR_CFG_RST = 32'h0002_0002;
    localparam logic [15:0] DIV_WRAP = 16'h0000;
    localparam logic [15:0] DIV_ONE = 16'h0001;
    localparam logic [15:0] DIV_MAXLIM = 16'hffff;
    // Watchdog block registers
    localparam logic [2:0] WD_CFG = 3'h0;
    localparam logic [2:0] WD_TMO0 = 3'h1;
    localparam logic [2:0] WD_TMO3 = 3'h4;
    localparam logic [2:0] WD_FEED = 3'h5;
    localparam logic [2:0] WD_PROT = 3'h6;
    localparam logic [2:0] WD_STAT = 3'h7;
    // Watchdog config fields
    localparam int WC_EN = 0;
    localparam int WC_ACT_LSB = 4;
    localparam int WC_SEN_LSB = 12;
    localparam logic [31:0] WD_CFG_RST_MAIN = 32'h0000_1020;
    localparam logic [31:0] WD_CFG_RST_LP = 32'h0000_1030;
    localparam logic [31:0] WD_TMO_RST = 32'hffff_ffff;
    // Arbitrary unlock key
    localparam logic [31:0] WD_KEY = 32'h5a5a_c3c3;
    localparam int WD_BOOT_MAIN = 0;
    localparam int WD_LP = 2;
    // Stage actions, one pulse bit each
    typedef enum logic [1:0] {
        ACT_IRQ = 2'h0,
        ACT_CPU = 2'h1,
        ACT_CORE = 2'h2,
        ACT_SYS = 2'h3
    } tgw_act_t;
    // Interrupt layout
    localparam logic [2:0] INT_STAT = 3'h0;
    localparam logic [2:0] INT_MASK = 3'h1;
    localparam int IRQ_W = 7;
endpackage

/* File: rtl/tgw_timer_group.sv */
// Purpose: Four 64-bit timers and three four-stage watchdogs behind Avalon-MM
// Assumes: Single clock; strap and bus inputs synchronous to clock
// Notes: Every bus access takes one wait cycle
//
// The Avalon-MM interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
module tgw_timer_group
    import tgw_pkg::*;
#(
    parameter logic [31:0] BOOT_TMO_CYCLES = 32'd2000000
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic flashBootStrap,
    output logic irq,
    output logic [3:0] timerEdgePulse,
    output logic cpuResetPulse,
    output logic coreResetPulse,
    output logic sysResetPulse
);

    logic ackReg_reg, ackReg_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [IRQ_W-1:0] status_reg, status_next;
    logic [IRQ_W-1:0] mask_reg, mask_next;
    logic bootSeen_reg, bootSeen_next;
    logic wrStb;
    logic [4:0] blk;
    logic [2:0] sub;
    logic [31:0] rdMux;
    wire [NUM_TMR-1:0] tmrEvt;
    wire [NUM_WD-1:0] wdIrq;
    wire [NUM_WD-1:0] wdCpu;
    wire [NUM_WD-1:0] wdCore;
    wire [NUM_WD-1:0] wdSys;
    wire [31:0] tmrRd [NUM_TMR];
    wire [31:0] wdRd [NUM_WD];

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        merge = (old & ~m) | (wd & m);
    endfunction

    // Write lands only at the edge where waitrequest is low
    assign wrStb = write & ackReg_reg;
    assign blk = address[7:3];
    assign sub = address[2:0];
    assign waitrequest = (read | write) & ~ackReg_reg;
    assign readdata = rdata_reg;
    // Level output, high while any unmasked event is pending
    assign irq = |(status_reg & mask_reg);
    assign cpuResetPulse = |wdCpu;
    assign coreResetPulse = |wdCore;
    assign sysResetPulse = |wdSys;

    for (genvar t = 0; t < NUM_TMR; t++) begin : g_tmr
        logic [31:0] cfg_reg, cfg_next;
        logic [15:0] psc_reg, psc_next;
        logic [63:0] cnt_reg, cnt_next;
        logic [63:0] alm_reg, alm_next;
        logic [63:0] ld_reg, ld_next;
        logic edge_reg, edge_next;
        logic sel;
        logic tick;
        logic hit;
        logic [15:0] div;
        logic [15:0] lim;
        logic [31:0] rd;

        // Next state of one timer
        always_comb begin
            sel = wrStb && (blk == 5'(t));
            div = cfg_reg[TC_DIV_LSB +: 16];
            if (div == DIV_WRAP) begin
                lim = DIV_MAXLIM;
            end else if (div == DIV_ONE) begin
                lim = DIV_ONE;
            end else begin
                lim = div - DIV_ONE;
            end
            cfg_next = cfg_reg;
            psc_next = psc_reg;
            cnt_next = cnt_reg;
            alm_next = alm_reg;
            ld_next = ld_reg;
            edge_next = 1'b0;
            // Compare with >= so a shrinking divider cannot strand the count
            tick = cfg_reg[TC_EN] && (psc_reg >= lim);
            hit = cfg_reg[TC_EN] && cfg_reg[TC_ALEN] && (cnt_reg == alm_reg);
            if (cfg_reg[TC_EN]) begin
                psc_next = tick ? '0 : psc_reg + DIV_ONE;
            end
            if (tick) begin
                cnt_next = cfg_reg[TC_UP] ? cnt_reg + 64'h1 : cnt_reg - 64'h1;
            end
            if (hit) begin
                edge_next = cfg_reg[TC_EDGE];
                if (cfg_reg[TC_AR]) begin
                    cnt_next = ld_reg;
                end else begin
                    cfg_next[TC_ALEN] = 1'b0;
                end
            end
            if (sel) begin
                unique case (sub)
                    TR_CFG: cfg_next = merge(cfg_reg, writedata, byteenable);
                    TR_CNT_LO: cnt_next[31:0] = merge(cnt_reg[31:0], writedata, byteenable);
                    TR_CNT_HI: cnt_next[63:32] = merge(cnt_reg[63:32], writedata, byteenable);
                    TR_ALM_LO: alm_next[31:0] = merge(alm_reg[31:0], writedata, byteenable);
                    TR_ALM_HI: alm_next[63:32] = merge(alm_reg[63:32], writedata, byteenable);
                    TR_LD_LO: ld_next[31:0] = merge(ld_reg[31:0], writedata, byteenable);
                    TR_LD_HI: ld_next[63:32] = merge(ld_reg[63:32], writedata, byteenable);
                    TR_RELOAD: cnt_next = ld_reg;
                endcase
            end
        end

        // Readback of one timer
        always_comb begin
            unique case (sub)
                TR_CFG: rd = cfg_reg;
                TR_CNT_LO: rd = cnt_reg[31:0];
                TR_CNT_HI: rd = cnt_reg[63:32];
                TR_ALM_LO: rd = alm_reg[31:0];
                TR_ALM_HI: rd = alm_reg[63:32];
                TR_LD_LO: rd = ld_reg[31:0];
                TR_LD_HI: rd = ld_reg[63:32];
                TR_RELOAD: rd = '0;
            endcase
        end

        // Timer registers
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                cfg_reg <= TMR_CFG_RST;
                psc_reg <= '0;
                cnt_reg <= '0;
                alm_reg <= '0;
                ld_reg <= '0;
                edge_reg <= 1'b0;
            end else begin
                cfg_reg <= cfg_next;
                psc_reg <= psc_next;
                cnt_reg <= cnt_next;
                alm_reg <= alm_next;
                ld_reg <= ld_next;
                edge_reg <= edge_next;
            end
        end

        assign tmrEvt[t] = hit & ~cfg_reg[TC_EDGE];
        assign timerEdgePulse[t] = edge_reg;
        assign tmrRd[t] = rd;
    end

    for (genvar w = 0; w < NUM_WD; w++) begin : g_wd
        localparam logic [31:0] CFG_RST = (w == WD_LP) ? WD_CFG_RST_LP : WD_CFG_RST_MAIN;
        logic [31:0] cfg_reg, cfg_next;
        logic [31:0] tmo_reg [NUM_STG];
        logic [31:0] tmo_next [NUM_STG];
        logic [31:0] cnt_reg, cnt_next;
        logic [1:0] stg_reg, stg_next;
        logic lock_reg, lock_next;
        logic [3:0] act_reg, act_next;
        logic sel;
        logic expire;
        logic [1:0] act;
        logic [31:0] rd;

        // Next state of one watchdog
        always_comb begin
            sel = wrStb && (blk == BLK_WD0 + 5'(w));
            cfg_next = cfg_reg;
            tmo_next = tmo_reg;
            cnt_next = cnt_reg;
            stg_next = stg_reg;
            lock_next = lock_reg;
            act_next = 4'h0;
            act = cfg_reg[WC_ACT_LSB + 2 * stg_reg +: 2];
            expire = cfg_reg[WC_EN] && (cnt_reg == tmo_reg[stg_reg]);
            if (!cfg_reg[WC_EN]) begin
                cnt_next = '0;
                stg_next = '0;
            end else if (expire) begin
                cnt_next = '0;
                stg_next = stg_reg + 2'h1;
                if (cfg_reg[WC_SEN_LSB + stg_reg]) begin
                    act_next = 4'h1 << act;
                end
            end else begin
                cnt_next = cnt_reg + 32'h1;
            end
            // main watchdogs cannot reset the system
            if (w != WD_LP) begin
                act_next[ACT_SYS] = 1'b0;
            end
            if (sel) begin
                if (sub == WD_FEED) begin
                    cnt_next = '0;
                    stg_next = '0;
                end
                if (sub == WD_PROT) begin
                    lock_next = (writedata != WD_KEY);
                end
                if (!lock_reg && sub == WD_CFG) begin
                    cfg_next = merge(cfg_reg, writedata, byteenable);
                end
                if (!lock_reg && sub >= WD_TMO0 && sub <= WD_TMO3) begin
                    tmo_next[2'(sub - WD_TMO0)] = merge(tmo_reg[2'(sub - WD_TMO0)], writedata,
                                                         byteenable);
                end
            end
            if (!bootSeen_reg && flashBootStrap && (w == WD_BOOT_MAIN || w == WD_LP)) begin
                cfg_next[WC_EN] = 1'b1;
            end
        end

        // Readback of one watchdog
        always_comb begin
            unique case (sub)
                WD_CFG: rd = cfg_reg;
                WD_FEED: rd = '0;
                WD_PROT: rd = {31'h0, lock_reg};
                WD_STAT: rd = {30'h0, stg_reg};
                default: rd = tmo_reg[2'(sub - WD_TMO0)];
            endcase
        end

        // Watchdog registers; stage zero carries the boot period
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                cfg_reg <= CFG_RST;
                for (int s = 0; s < NUM_STG; s++) begin
                    tmo_reg[s] <= (s == 0) ? BOOT_TMO_CYCLES : WD_TMO_RST;
                end
                cnt_reg <= '0;
                stg_reg <= '0;
                lock_reg <= 1'b1;
                act_reg <= 4'h0;
            end else begin
                cfg_reg <= cfg_next;
                tmo_reg <= tmo_next;
                cnt_reg <= cnt_next;
                stg_reg <= stg_next;
                lock_reg <= lock_next;
                act_reg <= act_next;
            end
        end

        assign wdIrq[w] = act_reg[ACT_IRQ];
        assign wdCpu[w] = act_reg[ACT_CPU];
        assign wdCore[w] = act_reg[ACT_CORE];
        assign wdSys[w] = act_reg[ACT_SYS];
        assign wdRd[w] = rd;
    end

    // Read decode; unmapped words read zero
    always_comb begin
        rdMux = '0;
        if (blk < BLK_WD0) begin
            rdMux = tmrRd[blk[1:0]];
        end else if (blk < BLK_INT) begin
            rdMux = wdRd[blk[1:0]];
        end else if (blk == BLK_INT && sub == INT_STAT) begin
            rdMux = {25'h0, status_reg};
        end else if (blk == BLK_INT && sub == INT_MASK) begin
            rdMux = {25'h0, mask_reg};
        end
    end

    // Bus handshake, interrupt status and boot capture
    always_comb begin
        ackReg_next = (read | write) & ~ackReg_reg;
        rdata_next = rdata_reg;
        if (read && !ackReg_reg) begin
            rdata_next = rdMux;
        end
        mask_next = mask_reg;
        status_next = status_reg;
        if (wrStb && blk == BLK_INT && sub == INT_MASK && byteenable[0]) begin
            mask_next = writedata[IRQ_W-1:0];
        end
        if (wrStb && blk == BLK_INT && sub == INT_STAT && byteenable[0]) begin
            status_next = status_reg & ~writedata[IRQ_W-1:0];
        end
        // New events win over a clear in the same cycle
        status_next = status_next | {wdIrq, tmrEvt};
        bootSeen_next = 1'b1;
    end

    // Bus and interrupt registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ackReg_reg <= 1'b0;
            rdata_reg <= '0;
            status_reg <= '0;
            mask_reg <= '0;
            bootSeen_reg <= 1'b0;
        end else begin
            ackReg_reg <= ackReg_next;
            rdata_reg <= rdata_next;
            status_reg <= status_next;
            mask_reg <= mask_next;
            bootSeen_reg <= bootSeen_next;
        end
    end

endmodule

/* File: bench/tgw_timer_group_props.sv */
// Purpose: Port checks for the timer group with watchdogs
// Assumes: Strap is steady across reset release
// Notes: Boot checks want a short boot timeout parameter
`timescale 1ns/1ps
module tgw_timer_group_props
    import tgw_pkg::*;
#(
    parameter logic [31:0] BOOT_TMO_CYCLES = 32'd2000000
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic flashBootStrap,
    input wire logic irq,
    input wire logic [3:0] timerEdgePulse,
    input wire logic cpuResetPulse,
    input wire logic coreResetPulse,
    input wire logic sysResetPulse
);
    logic firstCyc_reg, firstCyc_next, bootFlag_reg, bootFlag_next;
    logic [31:0] bootAge_reg, bootAge_next;
    logic [2:0] seen_reg, seen_next;

    // Strap taken in the first cycle; age saturates so it never wraps
    always_comb begin
        firstCyc_next = 1'b0;
        bootFlag_next = firstCyc_reg ? flashBootStrap : bootFlag_reg;
        bootAge_next = (&bootAge_reg) ? bootAge_reg : bootAge_reg + 32'h1;
        seen_next = seen_reg | {sysResetPulse, coreResetPulse, cpuResetPulse};
    end

    // Helper registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            firstCyc_reg <= 1'b1;
            bootFlag_reg <= 1'b0;
            bootAge_reg <= 32'h0;
            seen_reg <= 3'h0;
        end else begin
            firstCyc_reg <= firstCyc_next;
            bootFlag_reg <= bootFlag_next;
            bootAge_reg <= bootAge_next;
            seen_reg <= seen_next;
        end
    end

    default clocking dc @(posedge clock); endclocking
    default disable iff (rst);

    // The two steps of one access
    sequence waitCyc;
        (read || write) && waitrequest;
    endsequence
    sequence ackCyc;
        (read || write) && !waitrequest;
    endsequence

    req_wait_a: assert property (waitCyc |=> ackCyc)
        else $error("Access not answered after one wait cycle");
    one_wait_a: assert property (ackCyc |-> $past(waitrequest))
        else $error("Access answered without a wait cycle");
    idle_ready_a: assert property (!(read || write) |-> !waitrequest)
        else $error("Wait raised with no access");
    unmapped_zero_a: assert property (read && !waitrequest && address[7:3] > BLK_INT |-> readdata == 32'h0)
        else $error("Unmapped word read nonzero");
    rdata_hold_a: assert property ($changed(readdata) |-> read && !waitrequest)
        else $error("Read data changed outside a read");
    reset_pulse_a: assert property (!(cpuResetPulse && $past(cpuResetPulse)) &&
        !(coreResetPulse && $past(coreResetPulse)) && !(sysResetPulse && $past(sysResetPulse)))
        else $error("Reset action longer than one cycle");
    edge_pulse_a: assert property ((timerEdgePulse & $past(timerEdgePulse)) == 4'h0)
        else $error("Edge interrupt longer than one cycle");
    boot_early_a: assert property (bootAge_reg < BOOT_TMO_CYCLES |-> seen_reg == 3'h0)
        else $error("Action before the stage timeout");
    boot_action_a: assert property (
        bootFlag_reg && bootAge_reg == BOOT_TMO_CYCLES + 32'h8 |-> seen_reg == 3'b110)
        else $error("Flash boot watchdogs did not act");
endmodule

bind tgw_timer_group tgw_timer_group_props #(.BOOT_TMO_CYCLES(BOOT_TMO_CYCLES)) chk (
    .clock(clock), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .flashBootStrap(flashBootStrap), .irq(irq),
    .timerEdgePulse(timerEdgePulse), .cpuResetPulse(cpuResetPulse),
    .coreResetPulse(coreResetPulse), .sysResetPulse(sysResetPulse)
);

/* File: bench/tgw_timer_group_tb.sv */
// Purpose: Self-checking bench for the timer group with watchdogs
// Assumes: Boot timeout shortened to 50 cycles
// Notes: Timer counts allow one tick of slack for prescaler phase
`timescale 1ns/1ps
module tgw_timer_group_tb;
    import tgw_pkg::*;
    localparam logic [31:0] BOOT = 32'd50;
    localparam logic [4:0] WD1 = BLK_WD0 + 5'h1;
    localparam logic [31:0] STG_TMO [4] = '{32'd10, 32'd20, 32'd10, 32'd12};
    logic clock, rst, read, write, waitrequest, flashBootStrap, irq;
    logic cpuResetPulse, coreResetPulse, sysResetPulse;
    logic [7:0] address;
    logic [31:0] writedata, readdata, rd, seed, lo, cfg;
    logic [3:0] byteenable, timerEdgePulse;
    logic [4:0] blk;
    int numErrors = 0;
    int samplesChecked = 0;
    int nCpu, nCore, nSys, div, tk;
    int nEdge [4];

    tgw_timer_group #(.BOOT_TMO_CYCLES(BOOT)) uut (
        .clock(clock), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .flashBootStrap(flashBootStrap), .irq(irq),
        .timerEdgePulse(timerEdgePulse), .cpuResetPulse(cpuResetPulse),
        .coreResetPulse(coreResetPulse), .sysResetPulse(sysResetPulse)
    );

    // Free-running clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Pulses sampled mid-cycle, clear of the launching edge
    always @(negedge clock) begin
        nCpu += int'(cpuResetPulse);
        nCore += int'(coreResetPulse);
        nSys += int'(sysResetPulse);
        for (int i = 0; i < 4; i++) nEdge[i] += int'(timerEdgePulse[i]);
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Divider 0 and 1 never tick faster than every two cycles
    function automatic logic tickOk(input int t, input int d);
        int e;
        e = (d < 2) ? 2 : d;
        return t >= 38 / e && t <= 46 / e + 1;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samplesChecked++;
        if (got !== exp) begin
            numErrors++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One access; held until the rising edge that sees wait low, data taken there
    task automatic bus(input logic wr, input logic [4:0] b, input logic [2:0] r, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        address <= {b, r};
        writedata <= d;
        write <= wr;
        read <= ~wr;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (n >= 20) chk(32'h0, 32'h1, "bus timeout");
    endtask

    task automatic wr(input logic [4:0] b, input logic [2:0] r, input logic [31:0] d);
        bus(1'b1, b, r, d);
    endtask

    task automatic rc(input logic [4:0] b, input logic [2:0] r, input logic [31:0] e, input string what);
        bus(1'b0, b, r, 32'h0);
        chk(rd, e, what);
    endtask

    task automatic irqChk(input logic e);
        @(negedge clock);
        chk({31'h0, irq}, {31'h0, e}, "irq level");
    endtask

    task automatic doReset(input logic strap);
        @(posedge clock);
        rst <= 1'b1;
        flashBootStrap <= strap;
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        nCpu = 0;
        nCore = 0;
        nSys = 0;
        for (int i = 0; i < 4; i++) nEdge[i] = 0;
    endtask

    task automatic printVerdict();
        $display("Checks %0d, mismatches %0d", samplesChecked, numErrors);
        if (numErrors == 0 && samplesChecked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Hang guard, far beyond the expected thousand or so cycles
    initial begin
        repeat (20000) @(posedge clock);
        chk(32'h0, 32'h1, "run timeout");
        printVerdict();
    end

    // Main sequence
    initial begin
        rst = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 8'h0;
        writedata = 32'h0;
        byteenable = 4'hf;
        flashBootStrap = 1'b1;
        seed = 32'h4081;
        doReset(1'b1);
        repeat (BOOT + 20) @(posedge clock);
        chk(32'(nCore), 32'h1, "boot core reset");
        chk(32'(nSys), 32'h1, "boot system reset");
        chk(32'(nCpu), 32'h0, "boot cpu reset");
        rc(BLK_WD0, WD_STAT, 32'h1, "boot stage");
        doReset(1'b0);
        repeat (BOOT + 20) @(posedge clock);
        chk(32'(nCore + nSys), 32'h0, "no boot start");
        rc(BLK_WD0, WD_CFG, WD_CFG_RST_MAIN, "main cfg");
        rc(BLK_WD0 + 5'h2, WD_CFG, WD_CFG_RST_LP, "lp cfg");
        rc(BLK_WD0, WD_TMO0, BOOT, "stage0 timeout");
        rc(BLK_WD0, WD_TMO3, WD_TMO_RST, "stage3 timeout");
        rc(5'h0, TR_CFG, TMR_CFG_RST, "timer cfg");
        wr(5'h1f, 3'h0, 32'hffff_ffff);
        rc(5'h1f, 3'h0, 32'h0, "unmapped word");
        // Locked configuration ignores writes until the key arrives
        wr(WD1, WD_CFG, 32'h7b41);
        rc(WD1, WD_CFG, WD_CFG_RST_MAIN, "locked cfg");
        rc(WD1, WD_PROT, 32'h1, "lock flag");
        wr(WD1, WD_PROT, WD_KEY);
        rc(WD1, WD_PROT, 32'h0, "unlock flag");
        for (int s = 0; s < 4; s++) begin
            wr(WD1, WD_TMO0 + 3'(s), STG_TMO[s]);
            rc(WD1, WD_TMO0 + 3'(s), STG_TMO[s], "stage timeout");
        end
        // Lane 0 only: upper bytes keep the stored timeout
        byteenable <= 4'h1;
        wr(WD1, WD_TMO0, 32'hffff_ff0a);
        byteenable <= 4'hf;
        rc(WD1, WD_TMO0, STG_TMO[0], "byte lanes");
        // Stages: irq, cpu, system (masked on main), core but disabled
        wr(BLK_INT, INT_MASK, 32'h7f);
        wr(WD1, WD_CFG, 32'h7b41);
        repeat (2) begin
            repeat (4) @(posedge clock);
            wr(WD1, WD_FEED, 32'h0);
        end
        rc(WD1, WD_STAT, 32'h0, "fed stage");
        irqChk(1'b0);
        repeat (55) @(posedge clock);
        wr(WD1, WD_CFG, 32'h0);
        chk(32'(nCpu), 32'h1, "stage1 cpu reset");
        chk(32'(nCore + nSys), 32'h0, "masked actions");
        rc(WD1, WD_STAT, 32'h0, "disabled stage");
        rc(BLK_INT, INT_STAT, 32'h20, "watchdog status");
        irqChk(1'b1);
        wr(BLK_INT, INT_MASK, 32'h0);
        irqChk(1'b0);
        wr(BLK_INT, INT_STAT, 32'h20);
        rc(BLK_INT, INT_STAT, 32'h0, "status cleared");
        // Any value other than the key locks again
        wr(WD1, WD_PROT, 32'h1);
        rc(WD1, WD_PROT, 32'h1, "relock flag");
        for (int t = 0; t < 4; t++) begin
            seed = lfsr(seed);
            blk = 5'(t);
            wr(blk, TR_LD_LO, seed);
            wr(blk, TR_LD_HI, ~seed);
            wr(blk, TR_RELOAD, 32'h0);
            rc(blk, TR_CNT_LO, seed, "forced reload lo");
            rc(blk, TR_CNT_HI, ~seed, "forced reload hi");
            // Count from zero both ways, then halt
            div = (t == 0) ? 1 : 2 + int'(seed[2:0]);
            for (int k = 1; k < 3; k++) wr(blk, 3'(k), 32'h0);
            cfg = {16'(div), 16'h0} | 32'h1 | (32'(t % 2) << TC_UP);
            wr(blk, TR_CFG, cfg);
            repeat (40) @(posedge clock);
            wr(blk, TR_CFG, cfg & ~32'h1);
            rc(blk, TR_CNT_HI, (t % 2 == 1) ? 32'h0 : 32'hffff_ffff, "count hi");
            bus(1'b0, blk, TR_CNT_LO, 32'h0);
            lo = rd;
            tk = (t % 2 == 1) ? int'(lo) : -int'(lo);
            chk(32'(tickOk(tk, div)), 32'h1, "tick count");
            repeat (10) @(posedge clock);
            rc(blk, TR_CNT_LO, lo, "halted count");
            // Alarm at three reloads zero; timers 2 and 3 use edge mode
            for (int k = 1; k < 7; k++) wr(blk, 3'(k), (3'(k) == TR_ALM_LO) ? 32'h3 : 32'h0);
            cfg = 32'h0002_0017 | (32'(t / 2) << TC_EDGE);
            wr(blk, TR_CFG, cfg);
            repeat (30) @(posedge clock);
            wr(blk, TR_CFG, cfg & ~32'h1);
            bus(1'b0, blk, TR_CNT_LO, 32'h0);
            chk(32'(rd <= 32'h3), 32'h1, "auto reload");
            rc(BLK_INT, INT_STAT, (t >= 2) ? 32'h0 : 32'h1 << t, "level status");
            chk(32'((t >= 2) ? nEdge[t] >= 3 : nEdge[t] == 0), 32'h1, "edge pulses");
            wr(BLK_INT, INT_STAT, 32'h7f);
        end
        printVerdict();
    end
endmodule
